// file: rtl/sensor_ctl_pkg.sv
package sensor_ctl_pkg;
    // Register offsets (6-bit serial address space)
    localparam logic [5:0] ADDR_TAP_AXES = 6'h2A;
    localparam logic [5:0] ADDR_AXIS_EVENT_STATUS = 6'h2B;
    localparam logic [5:0] ADDR_RATE_AND_POWER_SELECT = 6'h2C;
    localparam logic [5:0] ADDR_POWER_MODE_CONTROL = 6'h2D;
    localparam logic [5:0] ADDR_IRQ_ENABLE_MASK = 6'h2E;
    localparam logic [5:0] ADDR_IRQ_PIN_ROUTING = 6'h2F;
    localparam logic [5:0] ADDR_IRQ_EVENT_FLAGS = 6'h30;
    localparam logic [5:0] ADDR_OUTPUT_FORMAT_CONTROL = 6'h31;
    localparam logic [5:0] ADDR_DATA_FIRST = 6'h32;
    localparam logic [5:0] ADDR_DATA_LAST = 6'h37;
    // Reset values
    localparam logic [7:0] RST_RATE_AND_POWER_SELECT = 8'h0A;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Rate register fields
    localparam int RATE_LOW_POWER_BIT = 4;
    localparam logic [7:0] RATE_WMASK = 8'h1F;
    // Power control fields
    localparam int PWR_LINK_BIT = 5;
    localparam int PWR_AUTO_SLEEP_BIT = 4;
    localparam int PWR_MEASURE_BIT = 3;
    localparam int PWR_SLEEP_BIT = 2;
    localparam logic [7:0] PWR_WMASK = 8'h3F;
    localparam logic [7:0] TAP_WMASK = 8'h0F;
    // Event flag / enable / routing bit order
    localparam int IRQ_DATA_READY = 7;
    localparam int IRQ_SINGLE_TAP = 6;
    localparam int IRQ_DOUBLE_TAP = 5;
    localparam int IRQ_ACTIVITY = 4;
    localparam int IRQ_INACTIVITY = 3;
    localparam int IRQ_FREE_FALL = 2;
    localparam int IRQ_WATERMARK = 1;
    localparam int IRQ_OVERRUN = 0;
    // Flags cleared by output data reads; the rest clear on a flag-register read
    localparam logic [7:0] IRQ_DATA_CLEARED = 8'h83;
    // Output format fields
    localparam int FMT_SELF_TEST_BIT = 7;
    localparam int FMT_WIRE3_BIT = 6;
    localparam int FMT_INVERT_BIT = 5;
    localparam int FMT_MAX_RESOLUTION_SELECT_BIT = 3;
    localparam int FMT_JUSTIFY_BIT = 2;
    localparam logic [7:0] FMT_WMASK = 8'hEF;
    localparam logic [1:0] RANGE_16G = 2'h3;
    // Sleep sampling rates in Hz
    localparam logic [3:0] SLEEP_HZ_BASE = 4'h8;
    // Serial frame layout
    localparam int CMD_READ_BIT = 7;
    localparam int CMD_MULTI_BIT = 6;
endpackage

// file: rtl/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
    logic req;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output req, output wr, output addr, output wdata, input rdata);
    modport regs (input req, input wr, input addr, input wdata, output rdata);
endinterface

// file: rtl/serial_reg_port.sv
`timescale 1ns/1ps
module serial_reg_port (
    input wire logic mclk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic cs_n, // Serial chip select, active low
    input wire logic sclk, // Serial clock, idles high
    input wire logic sdi, // Serial data in
    output logic sdo, // Serial data out
    output logic sdo_oe, // Drive enable for sdo
    reg_access_if.port bus // Register access toward the bank
);
    logic [2:0] cs_s_q, sclk_s_q;
    logic [1:0] sdi_s_q;
    logic [7:0] rx_q, tx_q;
    logic [2:0] bit_q;
    logic first_q, read_q, multi_q, load_q;
    logic [5:0] addr_q;
    logic rise, fall, in_frame, byte_done;
    logic [7:0] rx_byte;

    // Edge finding on the synchronised pins
    assign rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign in_frame = ~cs_s_q[1];
    assign byte_done = in_frame & rise & (bit_q == 3'h7);
    assign rx_byte = {rx_q[6:0], sdi_s_q[1]};

    // Two-stage synchronisers, third stage for edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s_q <= 3'h7;
            sclk_s_q <= 3'h7;
            sdi_s_q <= 2'h0;
        end else if (clk_en) begin
            cs_s_q <= {cs_s_q[1:0], cs_n};
            sclk_s_q <= {sclk_s_q[1:0], sclk};
            sdi_s_q <= {sdi_s_q[0], sdi};
        end
    end

    // Receive shifter and frame decode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= 8'h00;
            bit_q <= 3'h0;
            first_q <= 1'b1;
            read_q <= 1'b0;
            multi_q <= 1'b0;
            addr_q <= 6'h00;
            bus.req <= 1'b0;
            bus.wr <= 1'b0;
            bus.addr <= 6'h00;
            bus.wdata <= 8'h00;
        end else if (clk_en) begin
            bus.req <= 1'b0;
            if (!in_frame) begin
                bit_q <= 3'h0;
                first_q <= 1'b1;
                read_q <= 1'b0;
            end else if (rise) begin
                rx_q <= rx_byte;
                bit_q <= bit_q + 3'h1;
                if (byte_done && first_q) begin
                    first_q <= 1'b0;
                    read_q <= rx_byte[sensor_ctl_pkg::CMD_READ_BIT];
                    multi_q <= rx_byte[sensor_ctl_pkg::CMD_MULTI_BIT];
                    addr_q <= rx_byte[5:0];
                    bus.req <= rx_byte[sensor_ctl_pkg::CMD_READ_BIT];
                    bus.wr <= 1'b0;
                    bus.addr <= rx_byte[5:0];
                end else if (byte_done) begin
                    // Data byte: write it, or prefetch the next read byte
                    bus.req <= 1'b1;
                    bus.wr <= ~read_q;
                    bus.addr <= read_q ? (addr_q + {5'h00, multi_q}) : addr_q;
                    bus.wdata <= rx_byte;
                    addr_q <= addr_q + {5'h00, multi_q};
                end
            end
        end
    end

    // Transmit shifter, changes on falling clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            load_q <= 1'b0;
            tx_q <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (clk_en) begin
            load_q <= bus.req & ~bus.wr;
            sdo_oe <= in_frame & read_q & ~first_q;
            if (load_q) begin
                tx_q <= bus.rdata;
            end else if (in_frame && fall) begin
                sdo <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end
endmodule

// file: rtl/sensor_power_interrupt_control.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Tap axis bits include axis in taps
// R2 - Status shows first axes of latest event
// R3 - Disabled axis clears at next event
// R4 - Asleep bit changes only under auto sleep
// R5 - Low-power bit selects reduced power mode
// R6 - Rate field resets to 100 Hz code
// R7 - Host picks rate it can read
// R8 - Link serialises activity and inactivity detection
// R9 - Auto sleep on inactivity, wake on activity
// R10 - Auto sleep ignored without link
// R11 - Measure bit; standby after power-up
// R12 - Sleep gates ready, fifo, inactivity
// R13 - Wake-up field picks 8/4/2/1 Hz
// R14 - Host goes standby before clearing modes
// R15 - Enable bits in fixed event order
// R16 - Ready/watermark/overrun enables gate only interrupt
// R17 - Host configures before enabling interrupts
// R18 - Routing bit picks pin; pins OR
// R19 - Flags set; data ones clear on read
// R20 - Flag register read clears other flags
// R21 - Host reads status before clearing flags
// R22 - Format fields; clip except 16 g
// R23 - Polarity bit inverts both pins
// R24 - Zero watermark count sets watermark flag
// R25 - Pin active while enabled routed flag set
module sensor_power_interrupt_control (
    input wire logic mclk, // Core clock, 250 MHz
    input wire logic rst_n, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic cs_n, // Serial chip select
    input wire logic sclk, // Serial clock
    input wire logic sdi, // Serial data in
    output logic sdo, // Serial data out
    output logic sdo_oe, // High while driving sdo
    input wire logic [2:0] tap_axes_hit, // Axes over tap threshold, x y z
    input wire logic single_tap_evt, // Single tap pulse
    input wire logic double_tap_evt, // Double tap pulse
    input wire logic [2:0] act_axes_hit, // First axes of activity, x y z
    input wire logic act_evt, // Activity pulse
    input wire logic inact_evt, // Inactivity pulse
    input wire logic free_fall_evt, // Free fall pulse
    input wire logic data_ready_evt, // New sample pulse
    input wire logic watermark_evt, // Watermark reached pulse
    input wire logic overrun_evt, // Overrun pulse
    input wire logic watermark_count_zero, // Watermark sample count is zero
    input wire logic act_fn_en, // Any activity axis enabled
    input wire logic inact_fn_en, // Any inactivity axis enabled
    output logic [2:0] tap_axis_en, // Tap axes taking part
    output logic act_detect_en, // Activity detector running
    output logic inact_detect_en, // Inactivity detector running
    output logic measure_on, // Measurement mode
    output logic asleep, // Sleeping, manual or automatic
    output logic fifo_write_en, // Samples may enter fifo
    output logic low_power, // Reduced power operation
    output logic [3:0] out_rate_code, // Output data rate code
    output logic [3:0] sample_hz, // Sampling rate in sleep, Hz
    output logic self_test, // Self-test force
    output logic wire3_mode, // Three-wire serial mode
    output logic max_resolution_select, // Full resolution
    output logic justify_left, // Left-justified data
    output logic [1:0] g_range, // Range select
    output logic clip_en, // Clip output data
    output logic irq_pin_first, // First interrupt pin
    output logic irq_pin_second // Second interrupt pin
);
    reg_access_if bus ();
    logic [3:0] tap_axes_q;
    logic [7:0] status_q, rate_q, pwr_q, en_q, map_q, src_q, fmt_q;
    logic auto_sleep_q, seek_act_q;
    logic [7:0] src_set, src_clr, live;
    logic rd, wr, link_both, sleep_eff, tap_ok, act_take, inact_take;

    serial_reg_port u_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .bus(bus)
    );

    function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
        hit = (a == b);
    endfunction

    // Access strobes and event acceptance
    assign rd = bus.req & ~bus.wr;
    assign wr = bus.req & bus.wr;
    assign sleep_eff = pwr_q[sensor_ctl_pkg::PWR_SLEEP_BIT] | auto_sleep_q;
    assign link_both = pwr_q[sensor_ctl_pkg::PWR_LINK_BIT] & act_fn_en & inact_fn_en;
    assign tap_ok = |(tap_axes_hit & tap_axes_q[2:0]); // R1
    assign act_take = act_evt & act_detect_en;
    assign inact_take = inact_evt & inact_detect_en & ~sleep_eff; // R12

    // Event flag sources, in enable-register order
    always_comb begin
        src_set = 8'h00;
        src_set[sensor_ctl_pkg::IRQ_DATA_READY] = data_ready_evt; // R19
        src_set[sensor_ctl_pkg::IRQ_SINGLE_TAP] = single_tap_evt & tap_ok; // R1
        src_set[sensor_ctl_pkg::IRQ_DOUBLE_TAP] = double_tap_evt & tap_ok;
        src_set[sensor_ctl_pkg::IRQ_ACTIVITY] = act_take;
        src_set[sensor_ctl_pkg::IRQ_INACTIVITY] = inact_take;
        src_set[sensor_ctl_pkg::IRQ_FREE_FALL] = free_fall_evt;
        src_set[sensor_ctl_pkg::IRQ_WATERMARK] = watermark_evt | watermark_count_zero; // R24
        src_set[sensor_ctl_pkg::IRQ_OVERRUN] = overrun_evt;
        src_clr = 8'h00;
        if (rd && hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS)) begin
            src_clr = ~sensor_ctl_pkg::IRQ_DATA_CLEARED; // R20
        end else if (rd && bus.addr >= sensor_ctl_pkg::ADDR_DATA_FIRST
                && bus.addr <= sensor_ctl_pkg::ADDR_DATA_LAST) begin
            src_clr = sensor_ctl_pkg::IRQ_DATA_CLEARED; // R19
        end
        // Ready is held off the pins while asleep
        live = src_q & en_q;
        live[sensor_ctl_pkg::IRQ_DATA_READY] = live[sensor_ctl_pkg::IRQ_DATA_READY] & ~sleep_eff; // R12 R16
    end

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= sensor_ctl_pkg::RST_ZERO;
        end else if (clk_en) begin
            src_q <= (src_q & ~src_clr) | src_set; // R19 R20
        end
    end

    // Axis status, overwritten by each accepted tap or activity event, never cleared
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= sensor_ctl_pkg::RST_ZERO;
        end else if (clk_en) begin
            if (act_take) begin
                status_q[6:4] <= act_axes_hit; // R2 R3
            end
            if ((single_tap_evt | double_tap_evt) && tap_ok) begin
                status_q[2:0] <= tap_axes_hit & tap_axes_q[2:0]; // R2 R3
            end
            status_q[3] <= auto_sleep_q; // R4
        end
    end

    // Register writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tap_axes_q <= 4'h0;
            rate_q <= sensor_ctl_pkg::RST_RATE_AND_POWER_SELECT; // R6
            pwr_q <= sensor_ctl_pkg::RST_ZERO; // R11
            en_q <= sensor_ctl_pkg::RST_ZERO;
            map_q <= sensor_ctl_pkg::RST_ZERO;
            fmt_q <= sensor_ctl_pkg::RST_ZERO;
        end else if (clk_en && wr) begin
            if (hit(bus.addr, sensor_ctl_pkg::ADDR_TAP_AXES)) begin
                tap_axes_q <= bus.wdata[3:0];
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_RATE_AND_POWER_SELECT)) begin
                rate_q <= bus.wdata & sensor_ctl_pkg::RATE_WMASK;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL)) begin
                pwr_q <= bus.wdata & sensor_ctl_pkg::PWR_WMASK;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_ENABLE_MASK)) begin
                en_q <= bus.wdata; // R15
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_PIN_ROUTING)) begin
                map_q <= bus.wdata;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_OUTPUT_FORMAT_CONTROL)) begin
                fmt_q <= bus.wdata & sensor_ctl_pkg::FMT_WMASK; // R22
            end
        end
    end

    // Register reads, answered one cycle after the request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= 8'h00;
        end else if (clk_en && rd) begin
            if (hit(bus.addr, sensor_ctl_pkg::ADDR_TAP_AXES)) begin
                bus.rdata <= {4'h0, tap_axes_q};
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS)) begin
                bus.rdata <= status_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_RATE_AND_POWER_SELECT)) begin
                bus.rdata <= rate_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL)) begin
                bus.rdata <= pwr_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_ENABLE_MASK)) begin
                bus.rdata <= en_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_PIN_ROUTING)) begin
                bus.rdata <= map_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS)) begin
                bus.rdata <= src_q;
            end else if (hit(bus.addr, sensor_ctl_pkg::ADDR_OUTPUT_FORMAT_CONTROL)) begin
                bus.rdata <= fmt_q;
            end else begin
                bus.rdata <= 8'h00;
            end
        end
    end

    // Link phase and automatic sleep
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seek_act_q <= 1'b0;
            auto_sleep_q <= 1'b0;
        end else if (clk_en) begin
            if (inact_take) begin
                seek_act_q <= 1'b1; // R8
            end else if (act_take) begin
                seek_act_q <= 1'b0;
            end
            if (!(pwr_q[sensor_ctl_pkg::PWR_LINK_BIT] && pwr_q[sensor_ctl_pkg::PWR_AUTO_SLEEP_BIT])) begin
                auto_sleep_q <= 1'b0; // R10
            end else if (inact_take) begin
                auto_sleep_q <= 1'b1; // R9
            end else if (act_take) begin
                auto_sleep_q <= 1'b0; // R9
            end
        end
    end

    // Mode outputs and interrupt pins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act_detect_en <= 1'b0;
            inact_detect_en <= 1'b0;
            measure_on <= 1'b0;
            asleep <= 1'b0;
            fifo_write_en <= 1'b0;
            irq_pin_first <= 1'b0;
            irq_pin_second <= 1'b0;
            sample_hz <= 4'h0;
        end else if (clk_en) begin
            measure_on <= pwr_q[sensor_ctl_pkg::PWR_MEASURE_BIT]; // R11
            act_detect_en <= pwr_q[sensor_ctl_pkg::PWR_MEASURE_BIT] & (~link_both | seek_act_q); // R8
            inact_detect_en <= pwr_q[sensor_ctl_pkg::PWR_MEASURE_BIT] & ~sleep_eff
                & (~link_both | ~seek_act_q); // R8 R12
            asleep <= sleep_eff;
            fifo_write_en <= pwr_q[sensor_ctl_pkg::PWR_MEASURE_BIT] & ~sleep_eff; // R12
            sample_hz <= sensor_ctl_pkg::SLEEP_HZ_BASE >> pwr_q[1:0]; // R13
            irq_pin_first <= (|(live & ~map_q)) ^ fmt_q[sensor_ctl_pkg::FMT_INVERT_BIT]; // R18 R23 R25
            irq_pin_second <= (|(live & map_q)) ^ fmt_q[sensor_ctl_pkg::FMT_INVERT_BIT]; // R18 R23 R25
        end
    end

    // Straight field outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tap_axis_en <= 3'h0;
            low_power <= 1'b0;
            out_rate_code <= 4'h0;
            self_test <= 1'b0;
            wire3_mode <= 1'b0;
            max_resolution_select <= 1'b0;
            justify_left <= 1'b0;
            g_range <= 2'h0;
            clip_en <= 1'b0;
        end else if (clk_en) begin
            tap_axis_en <= tap_axes_q[2:0]; // R1
            low_power <= rate_q[sensor_ctl_pkg::RATE_LOW_POWER_BIT]; // R5
            out_rate_code <= rate_q[3:0];
            self_test <= fmt_q[sensor_ctl_pkg::FMT_SELF_TEST_BIT];
            wire3_mode <= fmt_q[sensor_ctl_pkg::FMT_WIRE3_BIT];
            max_resolution_select <= fmt_q[sensor_ctl_pkg::FMT_MAX_RESOLUTION_SELECT_BIT];
            justify_left <= fmt_q[sensor_ctl_pkg::FMT_JUSTIFY_BIT];
            g_range <= fmt_q[1:0];
            clip_en <= (fmt_q[1:0] != sensor_ctl_pkg::RANGE_16G); // R22
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    tap_gate_a: assert property (clk_en && single_tap_evt && !tap_ok && !src_q[6] |=> !src_q[6]) // R1
        else $error("tap flag set with no enabled axis");
    status_ow_a: assert property (clk_en && act_take |=> status_q[6:4] == $past(act_axes_hit)) // R2
        else $error("activity axes not captured");
    asleep_cfg_a: assert property (clk_en && !pwr_q[5] ##1 clk_en |-> !auto_sleep_q ##1 !status_q[3]) // R4
        else $error("asleep set without auto sleep");
    serial_link_a: assert property (clk_en && link_both && !seek_act_q |=> !act_detect_en) // R8
        else $error("activity ran before inactivity");
    auto_sleep_a: assert property (clk_en && inact_take && pwr_q[5] && pwr_q[4] ##1 clk_en // R9
        |-> auto_sleep_q ##1 asleep)
        else $error("no auto sleep after inactivity");
    sleep_fifo_a: assert property (clk_en && sleep_eff |=> !fifo_write_en && !inact_detect_en) // R12
        else $error("fifo or inactivity live in sleep");
    src_clear_a: assert property (clk_en && rd && bus.addr == 6'h30 // R20
        |=> (src_q & 8'h7C) == ($past(src_set) & 8'h7C))
        else $error("flag read did not clear");
    wm_zero_a: assert property (clk_en && watermark_count_zero |=> src_q[1]) // R24
        else $error("zero watermark count left flag clear");
    pin_route_a: assert property (clk_en |=> // R25
        irq_pin_second == ((|($past(live) & $past(map_q))) ^ $past(fmt_q[5])))
        else $error("second pin mismatch");
    clip_a: assert property (clk_en ##1 clk_en |-> clip_en == ($past(fmt_q[1:0]) != 2'h3)) // R22
        else $error("clip enable wrong");

    auto_sleep_c: cover property (inact_take && auto_sleep_q == 1'b0 && pwr_q[4] && pwr_q[5]);
    pin_two_c: cover property ($rose(irq_pin_second));
    multi_read_c: cover property (rd ##[1:200] rd);
    sleep_wake_c: cover property (auto_sleep_q ##1 !auto_sleep_q);
endmodule

// file: bench/spi_host_model.sv
`timescale 1ns/1ps
// Host side of the four-wire serial port, mode 3, MSB first
module spi_host_model (
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, idles high
    output logic sdi, // Data toward the device
    input wire logic sdo // Data from the device
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // One byte: change on fall, sample before rise
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = tx[i];
            #62.5;
            rx[i] = sdo;
            sclk = 1'b1;
            #62.5;
        end
    endtask
    // Command byte then one data byte
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] rx);
        logic [7:0] cmd_rx;
        cs_n = 1'b0;
        #100;
        shift({rd, 1'b0, a}, cmd_rx);
        shift(wd, rx);
        #100;
        cs_n = 1'b1;
        sdi = ~sdi;
        #200;
    endtask
endmodule

// file: bench/test_sensor_power_interrupt_control.sv
`timescale 1ns/1ps
// Self-checking bench
module test_sensor_power_interrupt_control;
    logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, cs_n, sclk, sdi, sdo, sdo_oe, clip_en, watermark_count_zero = 1'b0;
    logic act_fn_en = 1'b1, inact_fn_en = 1'b1, act_detect_en, inact_detect_en, measure_on, asleep, fifo_write_en;
    logic low_power, self_test, wire3_mode, max_resolution_select, justify_left, irq_pin_first, irq_pin_second;
    logic [2:0] tap_axes_hit = 3'h0, act_axes_hit = 3'h0, tap_axis_en;
    logic [3:0] out_rate_code, sample_hz;
    logic [1:0] g_range;
    logic [7:0] ev = 8'h00;
    int err_total = 0, n_checks = 0;
    sensor_power_interrupt_control i_sensor_power_interrupt_control (.mclk, .rst_n, .clk_en, .cs_n, .sclk, .sdi,
        .sdo, .sdo_oe, .tap_axes_hit, .single_tap_evt(ev[6]), .double_tap_evt(ev[5]), .act_axes_hit,
        .act_evt(ev[4]), .inact_evt(ev[3]), .free_fall_evt(ev[2]), .data_ready_evt(ev[7]), .watermark_evt(ev[1]),
        .overrun_evt(ev[0]), .watermark_count_zero, .act_fn_en, .inact_fn_en, .tap_axis_en, .act_detect_en,
        .inact_detect_en, .measure_on, .asleep, .fifo_write_en, .low_power, .out_rate_code, .sample_hz, .self_test,
        .wire3_mode, .max_resolution_select, .justify_left, .g_range, .clip_en, .irq_pin_first, .irq_pin_second);
    spi_host_model i_spi_host_model (.cs_n, .sclk, .sdi, .sdo);
    // Core clock
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_spi_host_model.xfer(1'b0, a, d, x);
    endtask
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] x;
        i_spi_host_model.xfer(1'b1, a, 8'h00, x);
        chk(nm, e, x);
    endtask
    // One-cycle event pulse with its axis levels
    task automatic pulse(input logic [7:0] v, input logic [2:0] th, input logic [2:0] ah);
        @(posedge mclk) #1;
        ev = v;
        tap_axes_hit = th;
        act_axes_hit = ah;
        @(posedge mclk) #1;
        ev = 8'h00;
        repeat (4) @(posedge mclk);
    endtask
    // Expected pin levels
    function automatic logic [1:0] pins(input logic [7:0] f, input logic [7:0] en, input logic [7:0] mp,
        input logic inv);
        return {|(f & en & mp), |(f & en & ~mp)} ^ {2{inv}};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        logic [7:0] en, mp, v, fm;
        void'($urandom(32'h9BC50436));
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        rdchk("rate", sensor_ctl_pkg::ADDR_RATE_AND_POWER_SELECT, sensor_ctl_pkg::RST_RATE_AND_POWER_SELECT);
        rdchk("power", sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h00);
        chk("measure_on", 8'h00, {measure_on, sdo_oe});
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            fm = {v[7:2], k[1:0]};
            wr(sensor_ctl_pkg::ADDR_RATE_AND_POWER_SELECT, v);
            wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h08 | 8'(k));
            wr(sensor_ctl_pkg::ADDR_OUTPUT_FORMAT_CONTROL, fm);
            rdchk("rate", sensor_ctl_pkg::ADDR_RATE_AND_POWER_SELECT, v & sensor_ctl_pkg::RATE_WMASK);
            rdchk("format", sensor_ctl_pkg::ADDR_OUTPUT_FORMAT_CONTROL, fm & sensor_ctl_pkg::FMT_WMASK);
            chk("rate outputs", {v[4], v[3:0]}, {low_power, out_rate_code});
            chk("sample_hz", 8'h08 >> k, sample_hz);
            chk("range", {k[1:0], k != 3}, {g_range, clip_en});
            chk("fmt outputs", {v[7:6], v[3:2]}, {self_test, wire3_mode, max_resolution_select, justify_left});
        end
        $display("test fields done");
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h08);
        wr(sensor_ctl_pkg::ADDR_TAP_AXES, 8'h07);
        for (int t = 0; t < 6; t++) begin
            en = 8'($urandom);
            mp = 8'($urandom);
            v = 8'($urandom) | 8'h01;
            wr(sensor_ctl_pkg::ADDR_IRQ_PIN_ROUTING, mp);
            wr(sensor_ctl_pkg::ADDR_OUTPUT_FORMAT_CONTROL, 8'(t[0]) << 5);
            wr(sensor_ctl_pkg::ADDR_IRQ_ENABLE_MASK, en);
            pulse(v, 3'h4, 3'h0);
            chk("pins set", pins(v, en, mp, t[0]), {irq_pin_second, irq_pin_first});
            rdchk("flags", sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS, v);
            v = v & sensor_ctl_pkg::IRQ_DATA_CLEARED;
            chk("pins kept", pins(v, en, mp, t[0]), {irq_pin_second, irq_pin_first});
            rdchk("flags kept", sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS, v);
            rdchk("data", sensor_ctl_pkg::ADDR_DATA_FIRST, 8'h00);
            rdchk("flags clear", sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS, 8'h00);
            chk("pins idle", {2{t[0]}}, {irq_pin_second, irq_pin_first});
        end
        $display("test interrupts done");
        pulse(8'h40, 3'h6, 3'h0);
        rdchk("tap axes", sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS, 8'h06);
        wr(sensor_ctl_pkg::ADDR_TAP_AXES, 8'h04);
        pulse(8'h40, 3'h6, 3'h0);
        rdchk("tap axes", sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS, 8'h04);
        pulse(8'h10, 3'h0, 3'h5);
        rdchk("act axes", sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS, 8'h54);
        rdchk("flags", sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS, 8'h50);
        $display("test axes done");
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h0C);
        chk("manual sleep", 8'h4A, {tap_axis_en, asleep, fifo_write_en, act_detect_en, inact_detect_en});
        rdchk("asleep bit", sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS, 8'h54);
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h00);
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h38);
        chk("linked", 8'h01, {asleep, act_detect_en, inact_detect_en});
        pulse(8'h08, 3'h0, 3'h0);
        chk("auto sleep", 8'h06, {asleep, act_detect_en, inact_detect_en});
        rdchk("asleep bit", sensor_ctl_pkg::ADDR_AXIS_EVENT_STATUS, 8'h5C);
        pulse(8'h10, 3'h0, 3'h5);
        chk("woken", 8'h01, {asleep, act_detect_en, inact_detect_en});
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h00);
        wr(sensor_ctl_pkg::ADDR_POWER_MODE_CONTROL, 8'h18);
        pulse(8'h08, 3'h0, 3'h0);
        chk("no link", 8'h03, {asleep, act_detect_en, inact_detect_en});
        @(posedge mclk) #1;
        watermark_count_zero = 1'b1;
        @(posedge mclk) #1;
        watermark_count_zero = 1'b0;
        rdchk("watermark", sensor_ctl_pkg::ADDR_IRQ_EVENT_FLAGS, 8'h1A);
        $display("test sleep done");
        report_and_stop();
    end
endmodule
